// File: inc/otsc_pkg.sv
package otsc_pkg;

   // ==========================================================
   // serial framing
   localparam logic [5:0] ADDR_FIXED = 6'h16;      // upper six address bits 010110
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int LOCK_BIT_POS = 7;                // instruction byte lock request
   localparam int DIR_BIT_POS = 0;                 // address byte direction bit

   // ==========================================================
   // wiper code
   localparam int CODE_W = 6;
   localparam int TAPS = 64;
   localparam logic [5:0] CODE_MIDSCALE = 6'h20;   // power-on preset

   // ==========================================================
   // permanent storage elements
   localparam int FUSE_N = 8;
   localparam logic [2:0] FUSE_TEST_IDX = 3'h6;
   localparam logic [2:0] FUSE_LOCK_IDX = 3'h7;

   // ==========================================================
   // programming status codes, returned in the top two read bits
   localparam logic [1:0] STAT_READY = 2'h0;
   localparam logic [1:0] STAT_TEST_FAIL = 2'h1;
   localparam logic [1:0] STAT_FATAL = 2'h2;
   localparam logic [1:0] STAT_DONE = 2'h3;

   // ==========================================================
   // timing: whole programming run and the share given to each element
   localparam longint CLK_PERIOD_PS = 4000;
   localparam longint PROG_TIME_MS = 400;
   localparam longint PROG_TIME_PS = PROG_TIME_MS * 64'd1000000000;
   localparam longint BLOW_CYCLES_CALC =
      (PROG_TIME_PS + CLK_PERIOD_PS * FUSE_N - 1) / (CLK_PERIOD_PS * FUSE_N);
   localparam logic [31:0] BLOW_CYCLES_DEF = BLOW_CYCLES_CALC[31:0];

endpackage

// File: src/otsc_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

// two-stage synchroniser followed by an edge stage
module otsc_pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // pins from outside the clock domain
   input wire logic [W-1:0] pinIn,
   // synchronised level and edge pulses
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);

   logic [W-1:0] meta_r;
   logic [W-1:0] prev_r;

   // idle-high reset matches a released open-drain line
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         meta_r <= '1;
         level <= '1;
         prev_r <= '1;
      end
      else
      begin
         meta_r <= pinIn;
         level <= meta_r;
         prev_r <= level;
      end
   end

   // edges only look at the settled stages, never the first one
   assign rise = level & ~prev_r;
   assign fall = ~level & prev_r;

endmodule
`default_nettype wire

// File: src/otsc_fuse_bank.sv
`timescale 1ns/1ns
`default_nettype none

// sequences the one-time programming run over the eight storage elements
module otsc_fuse_bank
   import otsc_pkg::*;
#(
   parameter logic [31:0] BLOW_CYCLES = BLOW_CYCLES_DEF
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // request from the serial side
   input wire logic progStart,
   input wire logic [CODE_W-1:0] progCode,
   // synchronised element states
   input wire logic [FUSE_N-1:0] fuseSense,
   // element drive
   output logic fuseBlowEn,
   output logic [2:0] fuseBlowSel,
   // state toward the serial side
   output logic [1:0] progStatus,
   output logic progBusy,
   output logic progRefused
);

   typedef enum logic [4:0] {
      FB_IDLE = 5'h01,
      FB_TEST = 5'h02,
      FB_DATA = 5'h04,
      FB_LOCK = 5'h08,
      FB_CHECK = 5'h10
   } otsc_fb_state_t;

   otsc_fb_state_t state_r;
   logic [31:0] timer_r;
   logic [CODE_W-1:0] code_r;
   logic testFail_r;
   logic fatal_r;
   wire timerDone = (timer_r == 32'h0);

   // one element at a time; each gets its full share of the supply
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_r <= FB_IDLE;
         timer_r <= 32'h0;
         code_r <= 6'h00;
         fuseBlowEn <= 1'b0;
         fuseBlowSel <= 3'h0;
         testFail_r <= 1'b0;
         fatal_r <= 1'b0;
      end
      else
      begin
         if (!timerDone)
            timer_r <= timer_r - 32'h1;
         case (state_r)
            FB_IDLE:
            begin
               if (progStart && !progRefused)
               begin
                  code_r <= progCode;
                  fuseBlowSel <= FUSE_TEST_IDX;
                  fuseBlowEn <= 1'b1;
                  timer_r <= BLOW_CYCLES;
                  state_r <= FB_TEST;
               end
            end
            FB_TEST:
            begin
               if (timerDone)
               begin
                  fuseBlowEn <= 1'b0;
                  if (!fuseSense[FUSE_TEST_IDX])
                  begin
                     testFail_r <= 1'b1;
                     state_r <= FB_IDLE;
                  end
                  else
                  begin
                     // elements for zero bits stay intact, so their slot is idle
                     fuseBlowSel <= 3'h0;
                     fuseBlowEn <= code_r[0];
                     timer_r <= BLOW_CYCLES;
                     state_r <= FB_DATA;
                  end
               end
            end
            FB_DATA:
            begin
               if (timerDone)
               begin
                  if (fuseBlowSel == 3'(CODE_W - 1))
                  begin
                     fuseBlowSel <= FUSE_LOCK_IDX;
                     fuseBlowEn <= 1'b1;
                     state_r <= FB_LOCK;
                  end
                  else
                  begin
                     fuseBlowSel <= fuseBlowSel + 3'h1;
                     fuseBlowEn <= code_r[fuseBlowSel + 3'h1];
                  end
                  timer_r <= BLOW_CYCLES;
               end
            end
            FB_LOCK:
            begin
               if (timerDone)
               begin
                  fuseBlowEn <= 1'b0;
                  state_r <= FB_CHECK;
               end
            end
            FB_CHECK:
            begin
               if (fuseSense[CODE_W-1:0] != code_r || !fuseSense[FUSE_LOCK_IDX])
                  fatal_r <= 1'b1;
               state_r <= FB_IDLE;
            end
            default:
               state_r <= FB_IDLE;
         endcase
      end
   end

   // status priority: fatal, then test failure, then the lock element
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         progStatus <= STAT_READY;
      else if (fatal_r)
         progStatus <= STAT_FATAL;
      else if (testFail_r)
         progStatus <= STAT_TEST_FAIL;
      else if (fuseSense[FUSE_LOCK_IDX] && state_r == FB_IDLE)
         progStatus <= STAT_DONE;
      else
         progStatus <= STAT_READY;
   end

   assign progBusy = (state_r != FB_IDLE);
   assign progRefused = fuseSense[FUSE_LOCK_IDX] | testFail_r | fatal_r;

endmodule
`default_nettype wire

// File: src/otsc_top.sv
`timescale 1ns/1ns
`default_nettype none

module otsc_top
   import otsc_pkg::*;
#(
   parameter logic [31:0] BLOW_CYCLES = BLOW_CYCLES_DEF
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // two-wire serial pins, data is open drain
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOeN,
   // address strap
   input wire logic addressSelectPin,
   // permanent storage elements
   input wire logic [FUSE_N-1:0] fuseSense,
   output logic fuseBlowEn,
   output logic [2:0] fuseBlowSel,
   // wiper
   output logic [CODE_W-1:0] wiperCode,
   output logic [TAPS-1:0] wiperTap,
   output logic [TAPS-1:0] tapToHighSel,
   output logic [1:0] otpStatus
);

   // ==========================================================
   // synchronised pins

   logic sclLvl;
   logic sclRise;
   logic sclFall;
   logic sdaLvl;
   logic sdaRise;
   logic sdaFall;
   logic addrSelLvl;
   logic [FUSE_N-1:0] senseLvl;
   logic [FUSE_N:0] miscLvlN;

   otsc_pin_sync #(.W(2)) u_bus_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .pinIn({sclIn, sdaIn}),
      .level({sclLvl, sdaLvl}),
      .rise({sclRise, sdaRise}),
      .fall({sclFall, sdaFall})
   );

   otsc_pin_sync #(.W(FUSE_N + 1)) u_misc_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .pinIn(~{addressSelectPin, fuseSense}), // stage resets high; intact must read 0
      .level(miscLvlN),
      .rise(),
      .fall()
   );
   assign {addrSelLvl, senseLvl} = ~miscLvlN;

   // bus conditions are only valid while the clock line is high
   wire startCond = sdaFall & sclLvl;
   wire stopCond = sdaRise & sclLvl;

   // ==========================================================
   // serial state machine

   typedef enum logic [9:0] {
      SS_IDLE = 10'h001,
      SS_ADDR = 10'h002,
      SS_ADDR_ACK = 10'h004,
      SS_INSTR = 10'h008,
      SS_INSTR_ACK = 10'h010,
      SS_DATA = 10'h020,
      SS_DATA_ACK = 10'h040,
      SS_RD_DATA = 10'h080,
      SS_RD_ACK = 10'h100,
      SS_IGNORE = 10'h200
   } otsc_ss_state_t;

   otsc_ss_state_t state_r;
   logic [3:0] bitCnt_r;
   logic [7:0] shift_r;
   logic lockReq_r;
   logic hostNack_r;
   logic commit_r;
   logic progStart_r;
   logic [CODE_W-1:0] code_r;
   logic progBusy;
   logic progRefused;
   logic [1:0] progStatus;

   wire byteDone = (bitCnt_r == BYTE_BITS);
   wire addrMatch = (shift_r[7:2] == ADDR_FIXED) && (shift_r[1] == addrSelLvl);
   wire [7:0] readByte = {progStatus, code_r};

   // receive side: bits are taken on the rising clock edge
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         shift_r <= 8'h00;
         bitCnt_r <= 4'h0;
         hostNack_r <= 1'b0;
      end
      else if (startCond)
         bitCnt_r <= 4'h0;
      else if (sclRise)
      begin
         case (state_r)
            SS_ADDR, SS_INSTR, SS_DATA:
            begin
               shift_r <= {shift_r[6:0], sdaLvl};
               bitCnt_r <= bitCnt_r + 4'h1;
            end
            SS_RD_ACK:
               hostNack_r <= sdaLvl;
            default:
            begin
            end
         endcase
      end
      else if (sclFall)
      begin
         case (state_r)
            SS_ADDR_ACK, SS_INSTR_ACK:
               bitCnt_r <= 4'h0;
            SS_RD_DATA:
            begin
               // read data shifts out most significant bit first
               shift_r <= {shift_r[6:0], 1'b0};
               bitCnt_r <= byteDone ? 4'h0 : bitCnt_r + 4'h1;
            end
            default:
            begin
            end
         endcase
         if ((state_r == SS_ADDR_ACK && shift_r[DIR_BIT_POS]) || state_r == SS_RD_ACK)
         begin
            shift_r <= {readByte[6:0], 1'b0};
            bitCnt_r <= 4'h1;
         end
      end
   end

   // transitions and line drive happen at a start or stop condition and on the falling clock edge
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_r <= SS_IDLE;
         sdaOeN <= 1'b1;
         lockReq_r <= 1'b0;
         commit_r <= 1'b0;
      end
      else
      begin
         commit_r <= 1'b0;
         if (startCond)
         begin
            state_r <= SS_ADDR;
            sdaOeN <= 1'b1;
         end
         else if (stopCond)
         begin
            // a stop before the data acknowledge leaves the latch alone
            state_r <= SS_IDLE;
            sdaOeN <= 1'b1;
         end
         else if (sclFall)
         begin
            case (state_r)
               SS_ADDR:
               begin
                  if (byteDone && addrMatch)
                  begin
                     state_r <= SS_ADDR_ACK;
                     sdaOeN <= 1'b0;
                  end
                  else if (byteDone)
                     state_r <= SS_IGNORE;
               end
               SS_ADDR_ACK:
               begin
                  if (shift_r[DIR_BIT_POS])
                  begin
                     state_r <= SS_RD_DATA;
                     sdaOeN <= readByte[7];
                  end
                  else
                  begin
                     state_r <= SS_INSTR;
                     sdaOeN <= 1'b1;
                  end
               end
               SS_INSTR:
               begin
                  if (byteDone)
                  begin
                     // only the top bit counts, the other seven are ignored
                     lockReq_r <= shift_r[LOCK_BIT_POS];
                     state_r <= SS_INSTR_ACK;
                     sdaOeN <= 1'b0;
                  end
               end
               SS_INSTR_ACK:
               begin
                  state_r <= SS_DATA;
                  sdaOeN <= 1'b1;
               end
               SS_DATA:
               begin
                  if (byteDone)
                  begin
                     state_r <= SS_DATA_ACK;
                     sdaOeN <= 1'b0;
                  end
               end
               SS_DATA_ACK:
               begin
                  // the acknowledge has been clocked; now the byte is final
                  commit_r <= 1'b1;
                  state_r <= SS_IGNORE;
                  sdaOeN <= 1'b1;
               end
               SS_RD_DATA:
               begin
                  if (byteDone)
                  begin
                     state_r <= SS_RD_ACK;
                     sdaOeN <= 1'b1;
                  end
                  else
                     sdaOeN <= shift_r[7];
               end
               SS_RD_ACK:
               begin
                  // a host acknowledge asks for the byte again
                  if (hostNack_r)
                     state_r <= SS_IGNORE;
                  else
                  begin
                     state_r <= SS_RD_DATA;
                     sdaOeN <= readByte[7];
                  end
               end
               SS_IDLE, SS_IGNORE:
                  sdaOeN <= 1'b1;
               default:
               begin
                  state_r <= SS_IDLE;
                  sdaOeN <= 1'b1;
               end
            endcase
         end
      end
   end

   // the line is only ever pulled low, never driven high
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         sdaOut <= 1'b0;
      else
         sdaOut <= 1'b0;
   end

   // ==========================================================
   // wiper latch

   // writes land only while unlocked; stored code wins once programmed
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         code_r <= CODE_MIDSCALE;
         progStart_r <= 1'b0;
      end
      else
      begin
         progStart_r <= 1'b0;
         if (senseLvl[FUSE_LOCK_IDX])
            code_r <= senseLvl[CODE_W-1:0];
         else if (commit_r && !progBusy && !progRefused)
         begin
            code_r <= shift_r[CODE_W-1:0];
            progStart_r <= lockReq_r;
         end
      end
   end

   // the programming run captures the code value just written
   otsc_fuse_bank #(.BLOW_CYCLES(BLOW_CYCLES)) u_fuse_bank (
      .clk_sys(clk_sys),
      .rst(rst),
      .progStart(progStart_r),
      .progCode(code_r),
      .fuseSense(senseLvl),
      .fuseBlowEn(fuseBlowEn),
      .fuseBlowSel(fuseBlowSel),
      .progStatus(progStatus),
      .progBusy(progBusy),
      .progRefused(progRefused)
   );

   // ==========================================================
   // tap decode

   // code 0 sits at the low end; each step moves one tap up the ladder
   function automatic logic [TAPS-1:0] tap_onehot(input logic [CODE_W-1:0] c);
      logic [TAPS-1:0] t;
      t = '0;
      t[c] = 1'b1;
      return t;
   endfunction

   // high-end switch sees the complement, so its resistance falls with code
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         wiperTap <= tap_onehot(CODE_MIDSCALE);
         tapToHighSel <= tap_onehot(~CODE_MIDSCALE);
         wiperCode <= CODE_MIDSCALE;
         otpStatus <= STAT_READY;
      end
      else
      begin
         wiperTap <= tap_onehot(code_r);
         tapToHighSel <= tap_onehot(~code_r);
         wiperCode <= code_r;
         otpStatus <= progStatus;
      end
   end

endmodule
`default_nettype wire

// File: verification/otsc_fuse_model.sv
`timescale 1ns/1ns
`default_nettype none

// =============================================
// nonvolatile element array seen from the part
module otsc_fuse_model
   import otsc_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // bench control: fresh part, elements that refuse to blow
   input wire logic wipe,
   input wire logic [FUSE_N-1:0] failMask,
   // element drive and sense
   input wire logic fuseBlowEn,
   input wire logic [2:0] fuseBlowSel,
   output logic [FUSE_N-1:0] fuseSense
);
   // no reset on purpose: blown elements must survive every reset of the part
   always_ff @(posedge clk_sys)
   begin
      if (wipe)
         fuseSense <= 8'h00;
      else if (fuseBlowEn && !failMask[fuseBlowSel])
         fuseSense[fuseBlowSel] <= 1'b1;
   end
endmodule

`default_nettype wire

// File: verification/otsc_props.sv
`timescale 1ns/1ns
`default_nettype none

// =============================================
// port checks for the trimmer control
module otsc_props
   import otsc_pkg::*;
#(
   parameter logic [31:0] BLOW_CYCLES = BLOW_CYCLES_DEF
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // serial pins
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOeN,
   // strap and storage
   input wire logic addressSelectPin,
   input wire logic [FUSE_N-1:0] fuseSense,
   input wire logic fuseBlowEn,
   input wire logic [2:0] fuseBlowSel,
   // wiper
   input wire logic [CODE_W-1:0] wiperCode,
   input wire logic [TAPS-1:0] wiperTap,
   input wire logic [TAPS-1:0] tapToHighSel,
   input wire logic [1:0] otpStatus
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   logic [31:0] blowCnt_r;
   logic [2:0] selQ_r;

   // cycles spent blowing one element; a stuck sequencer would overrun it
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         blowCnt_r <= 32'h0;
         selQ_r <= 3'h0;
      end
      else
      begin
         selQ_r <= fuseBlowSel;
         if (!fuseBlowEn || fuseBlowSel != selQ_r)
            blowCnt_r <= 32'h0;
         else
            blowCnt_r <= blowCnt_r + 32'h1;
      end
   end

   // =============================================
   // assertions
   chk_tap_onehot: assert property (wiperTap == (64'h1 << wiperCode))
      else $error("tap select does not match code");
   chk_high_complement: assert property (
      tapToHighSel == (64'h1 << (6'h3F - wiperCode)))
      else $error("high side select does not mirror code");
   chk_sda_pulls_low: assert property (!sdaOeN |-> !sdaOut)
      else $error("data pin driven high");
   chk_code_frozen: assert property (
      otpStatus == STAT_DONE && $past(otpStatus) == STAT_DONE |-> $stable(wiperCode))
      else $error("wiper moved after programming");
   chk_reset_midscale: assert property ($fell(rst) |-> wiperCode == CODE_MIDSCALE)
      else $error("wiper not midscale at reset release");
   chk_fatal_sticks: assert property (
      otpStatus == STAT_FATAL |=> otpStatus == STAT_FATAL)
      else $error("fatal status lost");
   chk_testfail_sticks: assert property (
      otpStatus == STAT_TEST_FAIL |=> otpStatus == STAT_TEST_FAIL)
      else $error("test fail status lost");
   chk_blow_when_ready: assert property (
      fuseBlowEn && fuseBlowSel != 3'h7 |-> otpStatus == STAT_READY)
      else $error("element blown while not ready");
   chk_blow_code_bit: assert property (
      fuseBlowEn && fuseBlowSel < 3'h6 |-> wiperCode[fuseBlowSel])
      else $error("code element blown for a zero bit");
   chk_blow_bounded: assert property (blowCnt_r <= BLOW_CYCLES)
      else $error("element blown too long");
endmodule

bind otsc_top otsc_props #(.BLOW_CYCLES(BLOW_CYCLES)) i_props (
   .clk_sys(clk_sys), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
   .sdaOeN(sdaOeN), .addressSelectPin(addressSelectPin), .fuseSense(fuseSense),
   .fuseBlowEn(fuseBlowEn), .fuseBlowSel(fuseBlowSel), .wiperCode(wiperCode),
   .wiperTap(wiperTap), .tapToHighSel(tapToHighSel), .otpStatus(otpStatus));

`default_nettype wire

// File: verification/otsc_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

// =============================================
// bench: bit-level serial host against the control block
module otsc_tb_top
   import otsc_pkg::*;
();
   // short element time keeps the programming run brief
   localparam logic [31:0] BLOW = 32'h14;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic sclIn = 1'b1;
   logic hostSda = 1'b1;
   logic addressSelectPin = 1'b0;
   logic wipe = 1'b1;
   logic [FUSE_N-1:0] failMask = 8'h00;
   logic sdaIn, sdaOut, sdaOeN, fuseBlowEn;
   logic [2:0] fuseBlowSel;
   logic [FUSE_N-1:0] fuseSense;
   logic [CODE_W-1:0] wiperCode;
   logic [TAPS-1:0] wiperTap, tapToHighSel;
   logic [1:0] otpStatus;
   logic [7:0] rd;
   int failures = 0;
   int num_checks = 0;

   always #2 clk_sys = ~clk_sys;
   // open-drain data line with pull-up
   assign sdaIn = hostSda & (sdaOeN | sdaOut);

   otsc_top #(.BLOW_CYCLES(BLOW)) i_dut (.clk_sys(clk_sys), .rst(rst), .sclIn(sclIn),
      .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .addressSelectPin(addressSelectPin),
      .fuseSense(fuseSense), .fuseBlowEn(fuseBlowEn), .fuseBlowSel(fuseBlowSel),
      .wiperCode(wiperCode), .wiperTap(wiperTap), .tapToHighSel(tapToHighSel),
      .otpStatus(otpStatus));
   otsc_fuse_model i_fuse (.clk_sys(clk_sys), .wipe(wipe), .failMask(failMask),
      .fuseBlowEn(fuseBlowEn), .fuseBlowSel(fuseBlowSel), .fuseSense(fuseSense));

   // =============================================
   // helpers
   task automatic w(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %s saw %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (failures == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic code(input logic [5:0] exp);
      chk({2'h0, wiperCode}, {2'h0, exp}, "wiper code");
   endtask
   task automatic stat(input logic [1:0] exp);
      chk({6'h00, otpStatus}, {6'h00, exp}, "status");
   endtask
   // pins move right after an edge; link period is 40 system clocks
   task automatic drv(input logic c, input logic d, input int n);
      sclIn <= c;
      hostSda <= d;
      w(n);
   endtask
   // data changes a quarter into the low phase, line read mid high phase
   task automatic bitx(input logic b, output logic r);
      drv(1'b0, hostSda, 5);
      drv(1'b0, b, 15);
      drv(1'b1, b, 10);
      r = sdaIn;
      w(10);
   endtask
   task automatic start();
      drv(1'b0, hostSda, 5);
      drv(1'b0, 1'b1, 15);
      drv(1'b1, 1'b1, 20);
      drv(1'b1, 1'b0, 20);
   endtask
   task automatic stop();
      drv(1'b0, hostSda, 5);
      drv(1'b0, 1'b0, 15);
      drv(1'b1, 1'b0, 20);
      drv(1'b1, 1'b1, 20);
   endtask
   task automatic sendByte(input logic [7:0] b, input logic expAck);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(b[i], r);
      bitx(1'b1, r);
      chk({7'h00, ~r}, {7'h00, expAck}, "acknowledge");
   endtask
   // write: address, instruction, then data unless cut short
   task automatic wr(input logic a, input logic [7:0] ins, input logic [7:0] dat,
      input logic full, input logic expAck);
      start();
      sendByte({ADDR_FIXED, a, 1'b0}, expAck);
      if (expAck)
      begin
         sendByte(ins, 1'b1);
         if (full)
            sendByte(dat, 1'b1);
      end
      stop();
      w(10);
   endtask
   // read n bytes: host acks all but the last, which it nacks
   task automatic rdChk(input logic [7:0] exp, input int n);
      logic r;
      start();
      sendByte({ADDR_FIXED, addressSelectPin, 1'b1}, 1'b1);
      for (int k = n; k > 0; k--)
      begin
         for (int i = 7; i >= 0; i--)
            bitx(1'b1, rd[i]);
         bitx(k == 1, r);
         chk(rd, exp, "read byte");
      end
      stop();
   endtask
   // bounded wait for the programming run to leave the ready status
   task automatic waitProg();
      int n = 0;
      while (otpStatus === STAT_READY && n < 1000)
      begin
         w(1);
         n++;
      end
      if (n >= 1000)
      begin
         failures++;
         complete_run();
      end
   endtask
   task automatic doRst(input logic fresh);
      rst <= 1'b1;
      wipe <= fresh;
      w(5);
      rst <= 1'b0;
      wipe <= 1'b0;
      w(10);
   endtask

   // =============================================
   // main sequence
   initial
   begin
      w(5);
      rst <= 1'b0;
      wipe <= 1'b0;
      w(10);
      code(CODE_MIDSCALE);
      stat(STAT_READY);
      // host ack on the first byte asks for the same byte again
      rdChk({STAT_READY, CODE_MIDSCALE}, 2);
      // upper data bits dropped, later writes replace earlier ones
      wr(1'b0, 8'h00, 8'hFF, 1'b1, 1'b1);
      code(6'h3F);
      wr(1'b0, 8'h7F, 8'hC0, 1'b1, 1'b1);
      code(6'h00);
      stat(STAT_READY);
      // strap mismatch ignored, match accepted
      addressSelectPin <= 1'b1;
      wr(1'b0, 8'h00, 8'h11, 1'b1, 1'b0);
      code(6'h00);
      wr(1'b1, 8'h00, 8'h11, 1'b1, 1'b1);
      code(6'h11);
      addressSelectPin <= 1'b0;
      // a write cut short before the data byte leaves the latch alone
      wr(1'b0, 8'h00, 8'h22, 1'b0, 1'b1);
      code(6'h11);
      // test element refuses to blow; the part then refuses further writes
      failMask <= 8'h40;
      wr(1'b0, 8'h80, 8'h15, 1'b1, 1'b1);
      waitProg();
      stat(STAT_TEST_FAIL);
      wr(1'b0, 8'h00, 8'h07, 1'b1, 1'b1);
      code(6'h15);
      // a code element refuses to blow on a fresh part; the stored code shows
      failMask <= 8'h01;
      doRst(1'b1);
      wr(1'b0, 8'h80, 8'h15, 1'b1, 1'b1);
      waitProg();
      rdChk({STAT_FATAL, 6'h14}, 1);
      // clean run on a fresh part, other instruction bits set
      failMask <= 8'h00;
      doRst(1'b1);
      code(CODE_MIDSCALE);
      wr(1'b0, 8'hFF, 8'h2A, 1'b1, 1'b1);
      waitProg();
      rdChk({STAT_DONE, 6'h2A}, 1);
      chk(fuseSense, 8'hEA, "elements");
      wr(1'b0, 8'h00, 8'h05, 1'b1, 1'b1);
      code(6'h2A);
      // power cycle: stored code returns instead of midscale
      doRst(1'b0);
      code(6'h2A);
      rdChk({STAT_DONE, 6'h2A}, 1);
      complete_run();
   end
endmodule

`default_nettype wire
